// file: design/audio_amp_front.sv
/*
 * Amplifier digital front end: audio clock checking with high-impedance
 * on fault, DC-block filter corner code, ramped per-channel volume, PWM rate,
 * spread and phase selection. Registers reached over the link port.
 * Assumes audio clocks asynchronous to core_clk and well below 10 MHz
 * when sampled (bench master clocks run at 10 MHz, synchronous to core_clk).
 */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module audio_amp_front #(
	parameter int CHANNELS = 2,
	parameter int TIMEOUT_CYC = audio_front_pkg::FS_TIMEOUT_CYC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic supplies_valid,
	audio_link_if.amp link,
	output logic [CHANNELS-1:0] high_impedance_state,
	output logic [CHANNELS*8-1:0] volume_now,
	output logic [3:0] hpf_corner,
	output logic [2:0] pwm_rate_code,
	output logic [1:0] pwm_phase_code,
	output logic spread_active,
	output logic [5:0] pwm_mult,
	output logic [1:0] gain_code,
	output logic clock_fault
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	logic [2:0] mc_s, bc_s, fs_s;
	logic [7:0] pwm_reg, pwm_next, hpf_reg, hpf_next, comp_reg, comp_next, ss_reg, ss_next;
	logic [7:0] ramp_reg, ramp_next, chan_reg, chan_next, rdata_reg, rdata_next;
	logic [CHANNELS*8-1:0] vtgt_reg, vtgt_next, vol_reg, vol_next;
	logic [audio_front_pkg::EDGE_CNT_W-1:0] mc_cnt_reg, mc_cnt_next, bc_cnt_reg, bc_cnt_next;
	logic [TW-1:0] fs_cyc_reg, fs_cyc_next;
	logic fault_reg, fault_next;
	logic [3:0] frm_reg, frm_next;
	logic mc_rise, bc_rise, fs_rise, ratio_ok, rate_ok, step;

	////////////////////////////////////////////////////////////////
	// Two-flop sync plus edge stage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mc_s <= 3'h0;
			bc_s <= 3'h0;
			fs_s <= 3'h0;
		end else begin
			mc_s <= {mc_s[1:0], link.master_clk};
			bc_s <= {bc_s[1:0], link.bit_clk};
			fs_s <= {fs_s[1:0], link.frame_sync};
		end
	end
	assign mc_rise = mc_s[1] & ~mc_s[2];
	assign bc_rise = bc_s[1] & ~bc_s[2];
	assign fs_rise = fs_s[1] & ~fs_s[2];

	////////////////////////////////////////////////////////////////
	// Clock checking
	always_comb begin
		ratio_ok = (mc_cnt_reg == 10'(audio_front_pkg::MCLK_128)) || (mc_cnt_reg == 10'(audio_front_pkg::MCLK_256))
			|| (mc_cnt_reg == 10'(audio_front_pkg::MCLK_512));
		ratio_ok = ratio_ok && ((bc_cnt_reg == 10'(audio_front_pkg::BCLK_32))
			|| (bc_cnt_reg == 10'(audio_front_pkg::BCLK_64)) || (bc_cnt_reg == 10'(audio_front_pkg::BCLK_128))
			|| (bc_cnt_reg == 10'(audio_front_pkg::BCLK_256)));
		rate_ok = (fs_cyc_reg >= TW'(audio_front_pkg::FS_MIN_CYC)) && (fs_cyc_reg <= TW'(audio_front_pkg::FS_MAX_CYC));
		mc_cnt_next = mc_cnt_reg;
		bc_cnt_next = bc_cnt_reg;
		fs_cyc_next = fs_cyc_reg;
		fault_next = fault_reg;
		if (fs_rise) begin
			fault_next = !(ratio_ok && rate_ok);
			mc_cnt_next = 10'(mc_rise);
			bc_cnt_next = 10'(bc_rise);
			fs_cyc_next = '0;
		end else begin
			if (mc_rise && mc_cnt_reg != '1)
				mc_cnt_next = mc_cnt_reg + 10'h001;
			if (bc_rise && bc_cnt_reg != '1)
				bc_cnt_next = bc_cnt_reg + 10'h001;
			if (fs_cyc_reg == TW'(TIMEOUT_CYC)) begin
				fault_next = 1'b1;
			end else begin
				fs_cyc_next = fs_cyc_reg + TW'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Ramp step every 1/2/4/8 frames
	always_comb begin
		frm_next = frm_reg;
		step = 1'b0;
		if (fs_rise && !fault_reg) begin
			if (frm_reg >= 4'((1 << ramp_reg[1:0]) - 1)) begin
				frm_next = 4'h0;
				step = 1'b1;
			end else begin
				frm_next = frm_reg + 4'h1;
			end
		end
	end

	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_ramp
			always_comb begin
				vol_next[c*8 +: 8] = vol_reg[c*8 +: 8];
				if (step && vol_reg[c*8 +: 8] < vtgt_reg[c*8 +: 8])
					vol_next[c*8 +: 8] = vol_reg[c*8 +: 8] + 8'h01;
				else if (step && vol_reg[c*8 +: 8] > vtgt_reg[c*8 +: 8])
					vol_next[c*8 +: 8] = vol_reg[c*8 +: 8] - 8'h01;
			end
			assign high_impedance_state[c] = chan_reg[c] | fault_reg;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Registers
	always_comb begin
		pwm_next = pwm_reg;
		hpf_next = hpf_reg;
		comp_next = comp_reg;
		ss_next = ss_reg;
		ramp_next = ramp_reg;
		chan_next = chan_reg;
		vtgt_next = vtgt_reg;
		rdata_next = rdata_reg;
		if (link.reg_wr) begin
			if (link.reg_addr == audio_front_pkg::PWM_CTRL_ADDR) begin
				pwm_next = link.reg_wdata;
			end else if (link.reg_addr == audio_front_pkg::HPF_CTRL_ADDR) begin
				hpf_next = link.reg_wdata;
			end else if (link.reg_addr == audio_front_pkg::SPREAD_COMP_ADDR) begin
				comp_next = link.reg_wdata;
			end else if (link.reg_addr == audio_front_pkg::SPREAD_EN_ADDR) begin
				ss_next = link.reg_wdata;
			end else if (link.reg_addr == audio_front_pkg::VOL_CH0_ADDR) begin
				vtgt_next[7:0] = (link.reg_wdata > audio_front_pkg::VOL_MAX) ? audio_front_pkg::VOL_MAX : link.reg_wdata;
			end else if (link.reg_addr == audio_front_pkg::VOL_CH1_ADDR) begin
				vtgt_next[15:8] = link.reg_wdata;
			end else if (link.reg_addr == audio_front_pkg::RAMP_CTRL_ADDR) begin
				ramp_next = link.reg_wdata;
			end else if (link.reg_addr == audio_front_pkg::CHAN_CTRL_ADDR) begin
				chan_next = link.reg_wdata;
			end
		end
		if (link.reg_rd) begin
			if (link.reg_addr == audio_front_pkg::PWM_CTRL_ADDR) begin
				rdata_next = pwm_reg;
			end else if (link.reg_addr == audio_front_pkg::HPF_CTRL_ADDR) begin
				rdata_next = hpf_reg;
			end else if (link.reg_addr == audio_front_pkg::SPREAD_COMP_ADDR) begin
				rdata_next = comp_reg;
			end else if (link.reg_addr == audio_front_pkg::SPREAD_EN_ADDR) begin
				rdata_next = ss_reg;
			end else if (link.reg_addr == audio_front_pkg::VOL_CH0_ADDR) begin
				rdata_next = vol_reg[7:0];
			end else if (link.reg_addr == audio_front_pkg::VOL_CH1_ADDR) begin
				rdata_next = vol_reg[15:8];
			end else if (link.reg_addr == audio_front_pkg::RAMP_CTRL_ADDR) begin
				rdata_next = ramp_reg;
			end else if (link.reg_addr == audio_front_pkg::STATUS_ADDR) begin
				rdata_next = {5'h00, spread_active, fault_reg, |high_impedance_state};
			end else if (link.reg_addr == audio_front_pkg::CHAN_CTRL_ADDR) begin
				rdata_next = chan_reg;
			end else begin
				rdata_next = 8'h00;
			end
		end
		if (!supplies_valid) begin
			ss_next[audio_front_pkg::SPREAD_BIT] = 1'b0;
			comp_next[7:audio_front_pkg::COMP_LSB] = 2'b00;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pwm_reg <= audio_front_pkg::PWM_CTRL_RESET;
			hpf_reg <= audio_front_pkg::HPF_CTRL_RESET;
			comp_reg <= 8'h00;
			ss_reg <= 8'h00;
			ramp_reg <= 8'h00;
			chan_reg <= 8'hFF;
			vtgt_reg <= {CHANNELS{audio_front_pkg::VOL_RESET}};
			vol_reg <= {CHANNELS{audio_front_pkg::VOL_RESET}};
			rdata_reg <= 8'h00;
			mc_cnt_reg <= '0;
			bc_cnt_reg <= '0;
			fs_cyc_reg <= '0;
			fault_reg <= 1'b1;
			frm_reg <= 4'h0;
		end else begin
			pwm_reg <= pwm_next;
			hpf_reg <= hpf_next;
			comp_reg <= comp_next;
			ss_reg <= ss_next;
			ramp_reg <= ramp_next;
			chan_reg <= chan_next;
			vtgt_reg <= vtgt_next;
			vol_reg <= vol_next;
			rdata_reg <= rdata_next;
			mc_cnt_reg <= mc_cnt_next;
			bc_cnt_reg <= bc_cnt_next;
			fs_cyc_reg <= fs_cyc_next;
			fault_reg <= fault_next;
			frm_reg <= frm_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	// corner field, default code 0
	assign hpf_corner = hpf_reg[audio_front_pkg::HPF_LSB +: 4];
	assign pwm_rate_code = pwm_reg[audio_front_pkg::FREQ_LSB +: 3];
	assign pwm_phase_code = pwm_reg[audio_front_pkg::PHASE_LSB +: 2];
	assign spread_active = ss_reg[audio_front_pkg::SPREAD_BIT] & (&comp_reg[7:audio_front_pkg::COMP_LSB]);
	assign gain_code = ramp_reg[5:4];
	assign volume_now = vol_reg;
	assign clock_fault = fault_reg;
	assign link.reg_rdata = rdata_reg;
	always_comb begin
		case (pwm_rate_code)
			audio_front_pkg::FREQ_8X: pwm_mult = 6'h08;
			audio_front_pkg::FREQ_10X: pwm_mult = 6'h0A;
			audio_front_pkg::FREQ_HI0: pwm_mult = 6'h26;
			audio_front_pkg::FREQ_HI1: pwm_mult = 6'h2C;
			audio_front_pkg::FREQ_HI2: pwm_mult = 6'h30;
			default: pwm_mult = 6'h00;
		endcase
	end
endmodule
`default_nettype wire

// file: design/audio_front_pkg.sv
/*
 * Shared constants for the audio clock, volume and PWM control block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 20 MHz core clock shared by both ends.
 */
package audio_front_pkg;
	localparam int CORE_CLK_HZ = 20000000;
	localparam logic [7:0] PWM_CTRL_ADDR = 8'h02;
	localparam logic [7:0] PWM_CTRL_RESET = 8'h62;
	localparam logic [7:0] HPF_CTRL_ADDR = 8'h26;
	localparam logic [7:0] HPF_CTRL_RESET = 8'h00;
	localparam logic [7:0] SPREAD_COMP_ADDR = 8'h28;
	localparam logic [7:0] SPREAD_EN_ADDR = 8'h77;
	localparam logic [7:0] VOL_CH0_ADDR = 8'h40;
	localparam logic [7:0] VOL_CH1_ADDR = 8'h41;
	localparam logic [7:0] RAMP_CTRL_ADDR = 8'h42;
	localparam logic [7:0] STATUS_ADDR = 8'h43;
	localparam logic [7:0] CHAN_CTRL_ADDR = 8'h44;
	localparam logic [7:0] VOL_RESET = 8'hCF;
	localparam logic [7:0] VOL_MAX = 8'hFF;
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam int FREQ_LSB = 4;
	localparam int PHASE_LSB = 2;
	localparam int HPF_LSB = 0;
	localparam int SPREAD_BIT = 7;
	localparam int COMP_LSB = 6;
	localparam logic [2:0] FREQ_8X = 3'h0;
	localparam logic [2:0] FREQ_10X = 3'h1;
	localparam logic [2:0] FREQ_HI0 = 3'h5;
	localparam logic [2:0] FREQ_HI1 = 3'h6;
	localparam logic [2:0] FREQ_HI2 = 3'h7;
	localparam int MCLK_128 = 128;
	localparam int MCLK_256 = 256;
	localparam int MCLK_512 = 512;
	localparam int BCLK_32 = 32;
	localparam int BCLK_64 = 64;
	localparam int BCLK_128 = 128;
	localparam int BCLK_256 = 256;
	localparam int FS_441_HZ = 44100;
	localparam int FS_48_HZ = 48000;
	localparam int FS_96_HZ = 96000;
	localparam int AUDIO_CLK_MAX_HZ = 25000000;
	localparam int FS_TOL_PCT = 2;
	localparam int FS_MIN_CYC = CORE_CLK_HZ / (FS_96_HZ * (100 + FS_TOL_PCT) / 100);
	localparam int FS_MAX_CYC = (CORE_CLK_HZ + FS_441_HZ * (100 - FS_TOL_PCT) / 100 - 1)
		/ (FS_441_HZ * (100 - FS_TOL_PCT) / 100);
	localparam int FS_TIMEOUT_CYC = 2 * FS_MAX_CYC;
	localparam int SPREAD_PCT = 8;
	localparam int FS_CNT_W = 12;
	localparam int EDGE_CNT_W = 10;
endpackage

// file: design/audio_link_if.sv
/*
 * Serial audio clock link and register port between the audio source
 * end and the amplifier front end. Plain point-to-point wires.
 */
`timescale 1ns/100ps
`default_nettype none
interface audio_link_if;
	logic master_clk;
	logic bit_clk;
	logic frame_sync;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	modport amp (
		input master_clk, bit_clk, frame_sync, reg_addr, reg_wdata, reg_wr, reg_rd,
		output reg_rdata
	);
	modport source (
		output master_clk, bit_clk, frame_sync, reg_addr, reg_wdata, reg_wr, reg_rd,
		input reg_rdata
	);
endinterface
`default_nettype wire

// file: design/audio_source_end.sv
/*
 * Audio source end: divides the core clock into master clock, bit clock
 * and frame sync, and forwards user register commands onto the link.
 * Assumes the ratios chosen keep every audio clock below 25 MHz.
 */
`timescale 1ns/100ps
`default_nettype none
module audio_source_end #(
	parameter int MCLK_HALF = 2,
	parameter int MCLK_PER_BCLK = 4,
	parameter int BCLK_PER_FS = 64
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_enable,
	input wire logic [7:0] user_addr,
	input wire logic [7:0] user_wdata,
	input wire logic user_wr,
	input wire logic user_rd,
	output logic [7:0] user_rdata,
	audio_link_if.source link
);
	logic [7:0] half_reg, half_next;
	logic [7:0] mcnt_reg, mcnt_next;
	logic [9:0] bcnt_reg, bcnt_next;
	logic mclk_reg, mclk_next, bclk_reg, bclk_next, fs_reg, fs_next;

	////////////////////////////////////////////////////////////////
	// even divider, 50% duty
	always_comb begin
		half_next = half_reg;
		mcnt_next = mcnt_reg;
		bcnt_next = bcnt_reg;
		mclk_next = mclk_reg;
		bclk_next = bclk_reg;
		fs_next = fs_reg;
		if (!clk_enable) begin
			mclk_next = 1'b0;
		end else if (half_reg == 8'(MCLK_HALF - 1)) begin
			half_next = 8'h00;
			mclk_next = ~mclk_reg;
			if (!mclk_reg) begin
				if (mcnt_reg == 8'(MCLK_PER_BCLK / 2 - 1)) begin
					mcnt_next = 8'h00;
					bclk_next = ~bclk_reg;
					if (bclk_reg) begin
						bcnt_next = (bcnt_reg == 10'(BCLK_PER_FS - 1)) ? 10'h000 : bcnt_reg + 10'h001;
						fs_next = (bcnt_next >= 10'(BCLK_PER_FS / 2));
					end
				end else begin
					mcnt_next = mcnt_reg + 8'h01;
				end
			end
		end else begin
			half_next = half_reg + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			half_reg <= 8'h00;
			mcnt_reg <= 8'h00;
			bcnt_reg <= 10'h000;
			mclk_reg <= 1'b0;
			bclk_reg <= 1'b0;
			fs_reg <= 1'b0;
		end else begin
			half_reg <= half_next;
			mcnt_reg <= mcnt_next;
			bcnt_reg <= bcnt_next;
			mclk_reg <= mclk_next;
			bclk_reg <= bclk_next;
			fs_reg <= fs_next;
		end
	end

	assign link.master_clk = mclk_reg;
	assign link.bit_clk = bclk_reg;
	assign link.frame_sync = fs_reg;
	assign link.reg_addr = user_addr;
	assign link.reg_wdata = user_wdata;
	assign link.reg_wr = user_wr;
	assign link.reg_rd = user_rd;
	assign user_rdata = link.reg_rdata;
endmodule
`default_nettype wire

// file: dv/audio_link_properties.sv
/*
 * Concurrent checks on the audio link and the amplifier front end outputs.
 * Assumes every signal lives in the core_clk domain and is fed by the bench top.
 */
`timescale 1ns/100ps
`default_nettype none
module audio_link_properties #(
	parameter int TIMEOUT_CYC = 1000
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic frame_sync,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic supplies_valid,
	input wire logic [1:0] high_impedance_state,
	input wire logic [15:0] volume_now,
	input wire logic [3:0] hpf_corner,
	input wire logic [2:0] pwm_rate_code,
	input wire logic [1:0] pwm_phase_code,
	input wire logic spread_active,
	input wire logic [5:0] pwm_mult,
	input wire logic clock_fault
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic fs_reg, fs_next, mapped;
	int quiet_reg, quiet_next;
	logic [5:0] mult_exp;
	////////////////////////////////////////////////////////////////////////
	// Cycles since the last frame rise, expected multiplier, address map
	always_comb begin
		fs_next = frame_sync;
		quiet_next = (frame_sync && !fs_reg) ? 0 : quiet_reg + 1;
		if (sys_rst)
			quiet_next = 0;
		mapped = reg_addr inside {8'h02, 8'h26, 8'h28, 8'h77, [8'h40:8'h44]};
		case (pwm_rate_code)
			3'h0: mult_exp = 6'h08;
			3'h1: mult_exp = 6'h0A;
			3'h5: mult_exp = 6'h26;
			3'h6: mult_exp = 6'h2C;
			3'h7: mult_exp = 6'h30;
			default: mult_exp = 6'h00;
		endcase
	end
	always_ff @(posedge core_clk) begin
		fs_reg <= fs_next;
		quiet_reg <= quiet_next;
	end
	hiz_on_fault_a: assert property (clock_fault |-> &high_impedance_state)
		else $error("channels not high impedance during clock fault");
	quiet_fault_a: assert property (quiet_reg > TIMEOUT_CYC + 8 |-> clock_fault)
		else $error("halted frame clock not flagged");
	rate_write_a: assert property (reg_wr && reg_addr == 8'h02 |=>
		pwm_rate_code == $past(reg_wdata[6:4]) && pwm_phase_code == $past(reg_wdata[3:2]))
		else $error("rate or phase field not taken");
	rate_read_a: assert property (reg_rd && reg_addr == 8'h02 |=>
		reg_rdata[6:4] == $past(pwm_rate_code) && reg_rdata[3:2] == $past(pwm_phase_code))
		else $error("rate register read mismatch");
	mult_map_a: assert property (pwm_mult == mult_exp)
		else $error("multiplier does not match rate code");
	hpf_write_a: assert property (reg_wr && reg_addr == 8'h26 |=> hpf_corner == $past(reg_wdata[3:0]))
		else $error("corner field not taken");
	unmapped_read_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	vol_step_a: assert property ($changed(volume_now[7:0]) |->
		volume_now[7:0] - $past(volume_now[7:0]) == 8'h01 || $past(volume_now[7:0]) - volume_now[7:0] == 8'h01)
		else $error("volume moved more than one step");
	spread_supply_a: assert property (!supplies_valid && !reg_wr |=> !spread_active)
		else $error("spread kept after supply loss");
	cover property ($rose(clock_fault));
	cover property ($fell(clock_fault));
	cover property ($changed(volume_now));
	cover property (spread_active);
endmodule
`default_nettype wire

// file: dv/tb_audio_clock_volume_pwm_control.sv
/*
 * Bench joining the source end and the front end, plus a second front end
 * fed by bench clocks with a breakable bit clock ratio.
 * Assumes source clocks of 256 core cycles per frame, 128 master, 32 bit clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_audio_clock_volume_pwm_control;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_enable = 1'b1;
	logic supplies_valid = 1'b1;
	logic [7:0] user_addr = 8'h00;
	logic [7:0] user_wdata = 8'h00;
	logic user_wr = 1'b0;
	logic user_rd = 1'b0;
	logic [7:0] user_rdata;
	logic [8:0] cnt_b = 9'h000;
	logic bad_bclk = 1'b0;
	logic slow_fs = 1'b0;
	logic [1:0] hiz_a, hiz_b, phase_a, gain_a;
	logic [15:0] vol_a;
	logic [3:0] hpf_a;
	logic [2:0] rate_a;
	logic [5:0] mult_a;
	logic spr_a, fault_a, fault_b;
	int n_fail = 0;
	int num_checks = 0;
	int seed = 38697;
	logic [7:0] mdl [int] = '{2: 8'h62, 'h26: 0, 'h28: 0, 'h77: 0, 'h40: 8'hCF, 'h41: 8'hCF, 'h42: 0, 'h44: 8'hFF};
	int mult_tab [8] = '{8, 10, 0, 0, 0, 38, 44, 48};
	audio_link_if link_a();
	audio_link_if link_b();
	audio_source_end #(.MCLK_HALF(1), .BCLK_PER_FS(32)) i_audio_source_end (.core_clk(core_clk),
		.sys_rst(sys_rst), .clk_enable(clk_enable), .user_addr(user_addr), .user_wdata(user_wdata),
		.user_wr(user_wr), .user_rd(user_rd), .user_rdata(user_rdata), .link(link_a));
	audio_amp_front #(.TIMEOUT_CYC(1000)) i_audio_amp_front (.core_clk(core_clk), .sys_rst(sys_rst),
		.supplies_valid(supplies_valid), .link(link_a), .high_impedance_state(hiz_a), .volume_now(vol_a),
		.hpf_corner(hpf_a), .pwm_rate_code(rate_a), .pwm_phase_code(phase_a), .spread_active(spr_a),
		.pwm_mult(mult_a), .gain_code(gain_a), .clock_fault(fault_a));
	audio_amp_front #(.TIMEOUT_CYC(1000)) i_audio_amp_front_b (.core_clk(core_clk), .sys_rst(sys_rst),
		.supplies_valid(supplies_valid), .link(link_b), .high_impedance_state(hiz_b), .volume_now(),
		.hpf_corner(), .pwm_rate_code(), .pwm_phase_code(), .spread_active(), .pwm_mult(), .gain_code(),
		.clock_fault(fault_b));
	audio_link_properties #(.TIMEOUT_CYC(1000)) i_audio_link_properties (.core_clk(core_clk), .sys_rst(sys_rst),
		.frame_sync(link_a.frame_sync), .reg_addr(link_a.reg_addr), .reg_wdata(link_a.reg_wdata),
		.reg_wr(link_a.reg_wr), .reg_rd(link_a.reg_rd), .reg_rdata(link_a.reg_rdata),
		.supplies_valid(supplies_valid), .high_impedance_state(hiz_a), .volume_now(vol_a), .hpf_corner(hpf_a),
		.pwm_rate_code(rate_a), .pwm_phase_code(phase_a), .spread_active(spr_a), .pwm_mult(mult_a),
		.clock_fault(fault_a));
	////////////////////////////////////////////////////////////////////////
	// Second link: 128 master and 32 bit clocks per frame, 16 when broken, 512-cycle frames when slowed
	always @(posedge core_clk) cnt_b <= cnt_b + 9'h001;
	assign link_b.master_clk = slow_fs ? cnt_b[1] : cnt_b[0];
	assign link_b.bit_clk = (slow_fs || bad_bclk) ? cnt_b[3] : cnt_b[2];
	assign link_b.frame_sync = slow_fs ? cnt_b[8] : cnt_b[7];
	assign link_b.reg_addr = user_addr;
	assign link_b.reg_wdata = user_wdata;
	assign link_b.reg_wr = user_wr;
	assign link_b.reg_rd = user_rd;
	initial forever #25 core_clk = ~core_clk;
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t output %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		user_addr <= a;
		user_wdata <= d;
		user_wr <= 1'b1;
		@(posedge core_clk);
		user_wr <= 1'b0;
		if (mdl.exists(a))
			mdl[a] = d;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		user_addr <= a;
		user_rd <= 1'b1;
		@(posedge core_clk);
		user_rd <= 1'b0;
		#1;
		chk_reg(user_rdata, mdl.exists(a) ? mdl[a] : 8'h00);
	endtask
	task automatic wait_fault(input logic b, input logic want);
		for (int k = 0; k < 4000 && (b ? fault_b : fault_a) !== want; k++)
			@(posedge core_clk);
		#1;
	endtask
	task automatic wait_vol(output int cyc);
		logic [7:0] v;
		v = vol_a[7:0];
		cyc = 0;
		while (vol_a[7:0] === v && cyc < 3000) begin
			@(posedge core_clk);
			#1;
			cyc++;
		end
		#1;
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		n_fail++;
		final_report;
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int c, i, r;
		logic [7:0] t;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		chk_out(hiz_a, 2'h3);
		rd(8'h02);
		rd(8'h26);
		rd(8'h40);
		rd(8'h41);
		rd(8'h44);
		rd(8'h10);
		wait_fault(0, 0);
		chk_out(fault_a, 1'b0);
		wait_fault(1, 0);
		chk_out(fault_b, 1'b0);
		wr(8'h44, 8'hFE);
		chk_out(hiz_a, 2'h2);
		@(posedge core_clk);
		clk_enable <= 1'b0;
		wait_fault(0, 1);
		chk_out(hiz_a, 2'h3);
		mdl['h43] = 8'h03;
		rd(8'h43);
		repeat (1500) @(posedge core_clk);
		clk_enable <= 1'b1;
		wait_fault(0, 0);
		chk_out(hiz_a, 2'h2);
		@(posedge core_clk);
		bad_bclk <= 1'b1;
		wait_fault(1, 1);
		chk_out(hiz_b, 2'h3);
		@(posedge core_clk);
		bad_bclk <= 1'b0;
		wait_fault(1, 0);
		chk_out(hiz_b, 2'h2);
		@(posedge core_clk);
		slow_fs <= 1'b1;
		wait_fault(1, 1);
		chk_out(fault_b, 1'b1);
		@(posedge core_clk);
		slow_fs <= 1'b0;
		wait_fault(1, 0);
		chk_out(fault_b, 1'b0);
		for (c = 0; c < 8; c++) begin
			r = $random(seed);
			wr(8'h02, {r[7], c[2:0], c[1:0], r[1:0]});
			chk_out(rate_a, c[2:0]);
			chk_out(mult_a, mult_tab[c]);
			chk_out(phase_a, c[1:0]);
			rd(8'h02);
		end
		r = $random(seed);
		wr(8'h26, r[7:0]);
		chk_out(hpf_a, r[3:0]);
		rd(8'h26);
		wr(8'h44, 8'hFF);
		wr(8'h77, 8'h80);
		chk_out(spr_a, 1'b0);
		wr(8'h28, 8'hC0);
		chk_out(spr_a, 1'b1);
		mdl['h43] = 8'h05;
		rd(8'h43);
		@(posedge core_clk);
		supplies_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
		supplies_valid <= 1'b1;
		#1;
		mdl['h77] = 8'h00;
		mdl['h28] = 8'h00;
		chk_out(spr_a, 1'b0);
		rd(8'h77);
		rd(8'h28);
		wr(8'h44, 8'hFE);
		for (c = 0; c < 4; c++) begin
			wr(8'h42, {2'h0, c[1:0], 2'h0, c[1:0]});
			chk_out(gain_a, c[1:0]);
			rd(8'h42);
			t = mdl['h40] + 8'h02;
			wr(8'h41, t);
			wr(8'h40, t);
			wait_vol(i);
			chk_out(vol_a[7:0], t - 8'h01);
			wait_vol(i);
			chk_out(vol_a[7:0], t);
			chk_out(i, 256 << c);
			repeat (256 << c) @(posedge core_clk);
			#1;
			chk_out(vol_a[15:8], t);
		end
		final_report;
	end
endmodule
`default_nettype wire
